// ===== rtl/prxs_defs.vh
// constants for the receive tlp stream port
`ifndef PRXS_DEFS_VH
`define PRXS_DEFS_VH

// ---------------------------------------------------------------------------
// stream timing
// ---------------------------------------------------------------------------
`define PRXS_READY_LATENCY 2
`define PRXS_FIFO_DEPTH 8
`define PRXS_FIFO_AW 3

// ---------------------------------------------------------------------------
// bus widths and modes
// ---------------------------------------------------------------------------
`define PRXS_DW_NARROW 64
`define PRXS_DW_WIDE 128
`define PRXS_NP_LIMIT_NARROW 14
`define PRXS_NP_LIMIT_WIDE 26

// ---------------------------------------------------------------------------
// bar hit vector layout (endpoint)
// ---------------------------------------------------------------------------
`define PRXS_BAR_W 8
`define PRXS_BAR_IDX_W 3
`define PRXS_BAR_ROM_BIT 6
`define PRXS_BAR_RSVD_BIT 7
`define PRXS_BAR_NONE 8'h00

// ---------------------------------------------------------------------------
// per byte secded code: bit 0 overall parity, bits 1..12 hamming positions
// ---------------------------------------------------------------------------
`define PRXS_CW 13
`define PRXS_INJ_BIT_A 3
`define PRXS_INJ_BIT_B 5

`endif

// ===== rtl/prxs_stream_port.v
// receive tlp stream port: ecc protected beat buffer and application stream
`timescale 1ns/100ps
`include "prxs_defs.vh"

// ---------------------------------------------------------------------------
// beat buffer
// ---------------------------------------------------------------------------
module prxs_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = `PRXS_FIFO_DEPTH,
   parameter AW = `PRXS_FIFO_AW
) (
   input wire clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r, rd_ptr_r;
   reg [AW:0] count_r;
   wire push, pop;

   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr_r];
   assign level = count_r;

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// Overview of operation
// - valid drops within two cycles after the application drops ready.
// - valid returns within two cycles of ready when data is waiting.
// - a beat is handed over only in cycles where valid is high.
// - valid may gap inside a packet even while ready stays high.
// - error output rises when buffered data has an uncorrectable ecc error.
// - error is high at least one cycle, together with valid.
// - each byte is secded protected: single bits fixed, double bits flagged.
// - an errored packet may end early with end-of-packet, then valid drops.
// - hold request stops non-posted requests; posted and completions keep flowing.
// - non-posted requests already buffered still go out under hold.
// - at most 14 (64-bit) or 26 (128-bit) non-posted go out after hold.
// - bar hit vector is meaningful for memory and i/o requests only.
// - bar hit vector is valid only on the first-beat cycle.
// - bits 0 to 5 flag hits on base address registers 0 to 5.
// - bit 6 flags an expansion rom hit; bit 7 is reserved.
// - a transfer may happen two cycles after the application raises ready.
// - first beat and last beat flags mark packet ends while valid is high.
// - 128-bit mode flags beats whose upper qword holds no data.
module prxs_stream_port #(
   parameter DW = `PRXS_DW_NARROW,
   parameter DEPTH = `PRXS_FIFO_DEPTH
) (
   input wire clk,
   input wire nrst,
   // transaction layer side
   input wire tl_valid,
   output reg tl_ready_r,
   output reg tl_np_stall_r,
   input wire [DW-1:0] tl_data,
   input wire tl_sop,
   input wire tl_eop,
   input wire tl_upper_void,
   input wire tl_is_np,
   input wire tl_is_request,
   input wire tl_bar_hit,
   input wire tl_bar_rom,
   input wire [`PRXS_BAR_IDX_W-1:0] tl_bar_index,
   input wire ecc_fault_flip1,
   input wire ecc_fault_flip2,
   // application side
   output reg rcv_beat_valid,
   input wire app_accept_ok,
   output reg [DW-1:0] rcv_payload_bus,
   output reg rcv_first_beat,
   output reg rcv_last_beat,
   output reg rcv_upper_qword_void,
   output reg rcv_buffer_uncorrectable,
   input wire nonposted_hold_request,
   output reg [`PRXS_BAR_W-1:0] bar_hit_vector
);
   localparam NB = DW / 8;
   localparam CWB = NB * `PRXS_CW;
   localparam W = CWB + 3 + `PRXS_BAR_W;
   localparam AW = `PRXS_FIFO_AW;
   localparam [1:0] ST_PASS = 2'b01;
   localparam [1:0] ST_DROP = 2'b10;

   // ------------------------------------------------------------------------
   // secded helpers
   // ------------------------------------------------------------------------
   function [`PRXS_CW-1:0] ecc_encode;
      input [7:0] d;
      reg [`PRXS_CW-1:0] c;
      integer i;
      integer k;
      begin
         c = {`PRXS_CW{1'b0}};
         k = 0;
         for (i = 1; i < `PRXS_CW; i = i + 1) begin
            if ((i & (i - 1)) != 0) begin
               c[i] = d[k];
               k = k + 1;
            end
         end
         for (i = 1; i < `PRXS_CW; i = i + 1) begin
            if (i[0]) c[1] = c[1] ^ ((i != 1) & c[i]);
            if (i[1]) c[2] = c[2] ^ ((i != 2) & c[i]);
            if (i[2]) c[4] = c[4] ^ ((i != 4) & c[i]);
            if (i[3]) c[8] = c[8] ^ ((i != 8) & c[i]);
         end
         c[0] = ^c[`PRXS_CW-1:1];
         ecc_encode = c;
      end
   endfunction

   // returns {double error, corrected byte}
   function [8:0] ecc_decode;
      input [`PRXS_CW-1:0] cw;
      reg [`PRXS_CW-1:0] c;
      reg [3:0] syn;
      reg [7:0] d;
      integer i;
      integer k;
      begin
         c = cw;
         syn = 4'h0;
         d = 8'h00;
         for (i = 1; i < `PRXS_CW; i = i + 1) begin
            if (c[i]) syn = syn ^ i[3:0];
         end
         // odd overall parity means one flip, which the syndrome locates
         if (^c && syn != 4'h0 && syn < `PRXS_CW) begin
            c[syn] = ~c[syn];
         end
         k = 0;
         for (i = 1; i < `PRXS_CW; i = i + 1) begin
            if ((i & (i - 1)) != 0) begin
               d[k] = c[i];
               k = k + 1;
            end
         end
         ecc_decode = {(~^cw) & (syn != 4'h0), d};
      end
   endfunction

   // ------------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------------
   reg rst_s1_r, rst_n_r;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // ------------------------------------------------------------------------
   // write side: encode, bar decode, non-posted hold
   // ------------------------------------------------------------------------
   wire [CWB-1:0] enc_bus;
   genvar g;
   generate
      for (g = 0; g < NB; g = g + 1) begin : g_enc
         wire [`PRXS_CW-1:0] cw;
         assign cw = ecc_encode(tl_data[g*8 +: 8]);
         if (g == 0) begin : g_inj
            // fault injection on byte 0 lets the error path be exercised
            wire [`PRXS_CW-1:0] flip;
            assign flip = ({{(`PRXS_CW-1){1'b0}}, ecc_fault_flip1 | ecc_fault_flip2}
                           << `PRXS_INJ_BIT_A)
                        | ({{(`PRXS_CW-1){1'b0}}, ecc_fault_flip2} << `PRXS_INJ_BIT_B);
            assign enc_bus[`PRXS_CW-1:0] = cw ^ flip;
         end else begin : g_pass
            assign enc_bus[g*`PRXS_CW +: `PRXS_CW] = cw;
         end
      end
   endgenerate

   reg [`PRXS_BAR_W-1:0] bar_in;
   always @* begin
      bar_in = `PRXS_BAR_NONE;
      if (tl_is_request && tl_sop) begin
         if (tl_bar_rom) begin
            bar_in[`PRXS_BAR_ROM_BIT] = 1'b1;
         end else if (tl_bar_hit && tl_bar_index < `PRXS_BAR_ROM_BIT) begin
            bar_in[tl_bar_index] = 1'b1;
         end
      end
      bar_in[`PRXS_BAR_RSVD_BIT] = 1'b0;
   end

   // only a new non-posted packet is refused; one already started runs on
   wire np_refuse, push, fifo_in_ready, void_in;
   wire [W-1:0] fifo_in;
   assign np_refuse = tl_np_stall_r & tl_sop & tl_is_np;
   assign push = tl_valid & tl_ready_r & ~np_refuse;
   assign void_in = (DW == `PRXS_DW_WIDE) ? tl_upper_void : 1'b0;
   assign fifo_in = {bar_in, tl_upper_void & void_in, tl_eop, tl_sop, enc_bus};

   // ------------------------------------------------------------------------
   // buffer
   // ------------------------------------------------------------------------
   wire fifo_out_valid, fifo_pop;
   wire [W-1:0] fifo_out;
   wire [AW:0] level;
   prxs_fifo #(
      .WIDTH(W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n_r),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out),
      .level(level)
   );

   // ------------------------------------------------------------------------
   // read side: decode head beat
   // ------------------------------------------------------------------------
   wire [DW-1:0] dec_data;
   wire [NB-1:0] dec_dbe;
   generate
      for (g = 0; g < NB; g = g + 1) begin : g_dec
         wire [8:0] r;
         assign r = ecc_decode(fifo_out[g*`PRXS_CW +: `PRXS_CW]);
         assign dec_data[g*8 +: 8] = r[7:0];
         assign dec_dbe[g] = r[8];
      end
   endgenerate

   wire head_sop, head_eop, head_void, head_bad;
   wire [`PRXS_BAR_W-1:0] head_bar;
   assign head_sop = fifo_out[CWB];
   assign head_eop = fifo_out[CWB+1];
   assign head_void = fifo_out[CWB+2];
   assign head_bar = fifo_out[W-1 -: `PRXS_BAR_W];
   assign head_bad = |dec_dbe;

   // ------------------------------------------------------------------------
   // ready latency and output stage
   // ------------------------------------------------------------------------
   reg rdy_d1_r;
   reg [1:0] state_r, state_nxt;
   wire send;
   // registering the delayed ready puts the beat on the port two cycles after ready
   assign send = (state_r == ST_PASS) & rdy_d1_r & fifo_out_valid;
   assign fifo_pop = send | ((state_r == ST_DROP) & fifo_out_valid);

   always @* begin
      case (state_r)
         ST_PASS: begin
            state_nxt = (send && head_bad && !head_eop) ? ST_DROP : ST_PASS;
         end
         ST_DROP: begin
            state_nxt = (fifo_out_valid && head_eop) ? ST_PASS : ST_DROP;
         end
         default: begin
            state_nxt = ST_PASS;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdy_d1_r <= 1'b0;
         state_r <= ST_PASS;
         tl_ready_r <= 1'b0;
         tl_np_stall_r <= 1'b0;
         rcv_beat_valid <= 1'b0;
         rcv_payload_bus <= {DW{1'b0}};
         rcv_first_beat <= 1'b0;
         rcv_last_beat <= 1'b0;
         rcv_upper_qword_void <= 1'b0;
         rcv_buffer_uncorrectable <= 1'b0;
         bar_hit_vector <= `PRXS_BAR_NONE;
      end else begin
         rdy_d1_r <= app_accept_ok;
         state_r <= state_nxt;
         // margin of two slots covers the push in flight behind the registered ready
         tl_ready_r <= fifo_in_ready && (level < DEPTH[AW:0] - 2'd2);
         // hold acts on the next packet start; buffered requests are untouched
         tl_np_stall_r <= nonposted_hold_request;
         rcv_beat_valid <= send;
         rcv_buffer_uncorrectable <= send & head_bad;
         rcv_first_beat <= send & head_sop;
         rcv_last_beat <= send & (head_eop | head_bad);
         rcv_upper_qword_void <= send & head_void;
         bar_hit_vector <= (send && head_sop) ? head_bar : `PRXS_BAR_NONE;
         if (send) begin
            rcv_payload_bus <= dec_data;
         end
      end
   end
endmodule

// ===== tb/prxs_app_model.sv
// application side model that takes received beats
`timescale 1ns/100ps
module prxs_app_model (
   input wire clk,
   input wire [1:0] mode,
   input wire rcv_beat_valid,
   input wire [63:0] rcv_payload_bus,
   input wire rcv_first_beat,
   input wire rcv_last_beat,
   input wire rcv_buffer_uncorrectable,
   input wire [7:0] bar_hit_vector,
   output reg app_accept_ok
);
   reg [3:0] ph = 4'h0;
   reg [74:0] cap [0:63];
   integer n = 0;
   initial app_accept_ok = 1'b0;
   // mode 0 prompt, 1 four on four off, 2 stalled; no core reset after errors
   always @(negedge clk) begin
      ph <= ph + 4'h1;
      app_accept_ok <= (mode == 2'h0) || (mode == 2'h1 && ph[2]);
   end
   // a beat counts only where valid is high; gaps and short packets are fine
   always @(posedge clk) begin
      if (rcv_beat_valid === 1'b1) begin
         // the bar field means nothing off a first beat, so it is kept as zero there
         cap[n] <= {rcv_first_beat, rcv_last_beat, rcv_buffer_uncorrectable,
            rcv_first_beat ? bar_hit_vector : 8'h00, rcv_payload_bus};
         n <= n + 1;
      end
   end
endmodule

// ===== tb/prxs_props.sv
// concurrent checks on the receive stream port outputs
`timescale 1ns/100ps
module prxs_props #(
   parameter DW = 64
) (
   input wire clk,
   input wire nrst,
   input wire tl_valid,
   input wire tl_ready_r,
   input wire tl_np_stall_r,
   input wire tl_sop,
   input wire tl_is_np,
   input wire rcv_beat_valid,
   input wire app_accept_ok,
   input wire rcv_first_beat,
   input wire rcv_last_beat,
   input wire rcv_upper_qword_void,
   input wire rcv_buffer_uncorrectable,
   input wire nonposted_hold_request,
   input wire [7:0] bar_hit_vector
);
   localparam int NP_MAX = (DW == 128) ? 26 : 14;
   reg [4:0] np_cnt_r;
   // -----------------------------------------------------------------
   // np requests taken while the hold request stands
   // -----------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         np_cnt_r <= 5'h00;
      else if (!nonposted_hold_request)
         np_cnt_r <= 5'h00;
      else if (tl_valid && tl_ready_r && tl_sop && tl_is_np && !tl_np_stall_r)
         np_cnt_r <= np_cnt_r + 5'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_valid_after_ready: assert property (!app_accept_ok |-> ##2 !rcv_beat_valid)
      else $error("valid two cycles after ready low");
   chk_first_has_valid: assert property (rcv_first_beat |-> rcv_beat_valid)
      else $error("first beat without valid");
   chk_last_has_valid: assert property (rcv_last_beat |-> rcv_beat_valid)
      else $error("last beat without valid");
   chk_err_ends_packet: assert property (rcv_buffer_uncorrectable |-> rcv_beat_valid && rcv_last_beat)
      else $error("error beat not a valid last beat");
   chk_bar_first_only: assert property (!rcv_first_beat |-> bar_hit_vector == 8'h00)
      else $error("bar vector off first beat");
   chk_bar_code: assert property (rcv_first_beat |-> $onehot0(bar_hit_vector) && !bar_hit_vector[7])
      else $error("bar vector not one hot");
   chk_void_wide_only: assert property (rcv_upper_qword_void |-> rcv_beat_valid && DW == 128)
      else $error("upper void flag misplaced");
   chk_np_bound: assert property (np_cnt_r <= NP_MAX)
      else $error("too many np requests under hold");
endmodule

bind prxs_stream_port prxs_props #(.DW(DW)) u_props (.clk(clk), .nrst(nrst), .tl_valid(tl_valid),
   .tl_ready_r(tl_ready_r), .tl_np_stall_r(tl_np_stall_r), .tl_sop(tl_sop), .tl_is_np(tl_is_np),
   .rcv_beat_valid(rcv_beat_valid), .app_accept_ok(app_accept_ok),
   .rcv_first_beat(rcv_first_beat), .rcv_last_beat(rcv_last_beat),
   .rcv_upper_qword_void(rcv_upper_qword_void),
   .rcv_buffer_uncorrectable(rcv_buffer_uncorrectable),
   .nonposted_hold_request(nonposted_hold_request), .bar_hit_vector(bar_hit_vector));

// ===== tb/prxs_stream_port_tb.sv
// self-checking bench of the receive stream port
`timescale 1ns/100ps
module prxs_stream_port_tb;
   reg clk = 1'b0;
   reg nrst = 1'b0;
   reg tl_valid = 1'b0, tl_sop = 1'b0, tl_eop = 1'b0, tl_is_np = 1'b0, tl_is_request = 1'b0;
   reg tl_bar_hit = 1'b0, tl_bar_rom = 1'b0, ecc_fault_flip1 = 1'b0, ecc_fault_flip2 = 1'b0;
   reg nonposted_hold_request = 1'b0, tl_upper_void = 1'b0;
   reg sent = 1'b0;
   reg [2:0] tl_bar_index = 3'h0;
   reg [63:0] tl_data = 64'h0;
   reg [1:0] mode = 2'h0;
   reg [7:0] pk = 8'h00;
   reg [7:0] p;
   wire tl_ready_r, tl_np_stall_r, rcv_beat_valid, app_accept_ok, rcv_first_beat;
   wire rcv_last_beat, rcv_upper_qword_void, rcv_buffer_uncorrectable;
   wire [63:0] rcv_payload_bus;
   wire [7:0] bar_hit_vector;
   integer mismatches = 0, tests_run = 0, cyc = 0, base = 0, i;

   always #5 clk = ~clk;

   prxs_stream_port #(.DW(64), .DEPTH(8)) dut (.clk(clk), .nrst(nrst), .tl_valid(tl_valid),
      .tl_ready_r(tl_ready_r), .tl_np_stall_r(tl_np_stall_r), .tl_data(tl_data),
      .tl_sop(tl_sop), .tl_eop(tl_eop), .tl_upper_void(tl_upper_void), .tl_is_np(tl_is_np),
      .tl_is_request(tl_is_request), .tl_bar_hit(tl_bar_hit), .tl_bar_rom(tl_bar_rom),
      .tl_bar_index(tl_bar_index), .ecc_fault_flip1(ecc_fault_flip1),
      .ecc_fault_flip2(ecc_fault_flip2), .rcv_beat_valid(rcv_beat_valid),
      .app_accept_ok(app_accept_ok), .rcv_payload_bus(rcv_payload_bus),
      .rcv_first_beat(rcv_first_beat), .rcv_last_beat(rcv_last_beat),
      .rcv_upper_qword_void(rcv_upper_qword_void),
      .rcv_buffer_uncorrectable(rcv_buffer_uncorrectable),
      .nonposted_hold_request(nonposted_hold_request), .bar_hit_vector(bar_hit_vector));

   prxs_app_model app (.clk(clk), .mode(mode), .rcv_beat_valid(rcv_beat_valid),
      .rcv_payload_bus(rcv_payload_bus), .rcv_first_beat(rcv_first_beat),
      .rcv_last_beat(rcv_last_beat), .rcv_buffer_uncorrectable(rcv_buffer_uncorrectable),
      .bar_hit_vector(bar_hit_vector), .app_accept_ok(app_accept_ok));

   task end_of_test;
      begin
         if (mismatches == 0 && tests_run > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   task automatic chk(input [74:0] seen, input [74:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // bar: 0..5 base register hit, 6 rom hit, 7 none; eb is the beat given a double flip
   task send(input integer nb, input np, input rq, input [2:0] bar, input integer eb,
      input f1);
      integer b, w;
      begin
         sent = 1'b0;
         for (b = 0; b < nb; b = b + 1) begin
            @(negedge clk);
            tl_data = {56'h0, pk[3:0], b[3:0]};
            {tl_valid, tl_sop, tl_eop, tl_is_np, tl_is_request} = {1'b1, b == 0, b == nb - 1, np, rq};
            {tl_bar_hit, tl_bar_rom, tl_bar_index} = {bar < 3'h6, bar == 3'h6, bar};
            {ecc_fault_flip1, ecc_fault_flip2} = {f1, b == eb};
            tl_upper_void = b == nb - 1;
            w = 0;
            @(posedge clk);
            while (!(tl_ready_r === 1'b1 && !(tl_np_stall_r === 1'b1 && b == 0 && np)) && w < 300) begin
               w = w + 1;
               @(posedge clk);
            end
            if (w == 300) mismatches = mismatches + 1;
         end
         @(negedge clk);
         tl_valid = 1'b0;
         pk = pk + 8'h01;
         sent = 1'b1;
      end
   endtask

   task wait_n(input integer k);
      integer w;
      begin
         for (w = 0; w < 400 && app.n < base + k; w = w + 1)
            @(posedge clk);
         chk(app.n - base, k);
      end
   endtask

   task s_bar;
      begin
         base = app.n;
         p = pk;
         for (i = 0; i < 8; i = i + 1)
            send(1, 0, 1, i, -1, 0);
         send(1, 0, 0, 3'h2, -1, 0);
         wait_n(9);
         for (i = 0; i < 8; i = i + 1)
            chk(app.cap[base + i], {3'b110, i < 6 ? 8'h01 << i : i == 6 ? 8'h40 : 8'h00, 56'h0, p[3:0] + i[3:0], 4'h0});
         chk(app.cap[base + 8], {3'b110, 8'h00, 56'h0, p[3:0] + 4'h8, 4'h0});
      end
   endtask

   task s_ecc;
      begin
         base = app.n;
         p = pk;
         send(1, 0, 0, 3'h7, -1, 1);
         send(4, 0, 0, 3'h7, 1, 0);
         send(2, 0, 0, 3'h7, -1, 0);
         wait_n(5);
         chk(app.cap[base], {3'b110, 8'h00, 56'h0, p[3:0], 4'h0});
         chk(app.cap[base + 1], {3'b100, 8'h00, 56'h0, p[3:0] + 4'h1, 4'h0});
         chk(app.cap[base + 2][74:64], {3'b011, 8'h00});
         chk(app.cap[base + 3], {3'b100, 8'h00, 56'h0, p[3:0] + 4'h2, 4'h0});
         chk(app.cap[base + 4], {3'b010, 8'h00, 56'h0, p[3:0] + 4'h2, 4'h1});
      end
   endtask

   task s_burst;
      integer w;
      begin
         base = app.n;
         p = pk;
         mode = 2'h2;
         fork
            send(12, 0, 0, 3'h7, -1, 0);
            begin
               for (w = 0; w < 100 && tl_ready_r !== 1'b0; w = w + 1)
                  @(posedge clk);
               chk(tl_ready_r, 1'b0);
               chk(rcv_beat_valid, 1'b0);
               // mode changes after a rising edge so the model's falling edge sees it settled
               @(posedge clk);
               mode = 2'h0;
               repeat (3) @(negedge clk);
               chk(rcv_beat_valid, 1'b1);
               @(posedge clk);
               mode = 2'h1;
            end
         join
         wait_n(12);
         for (i = 0; i < 12; i = i + 1)
            chk(app.cap[base + i], {i == 0, i == 11, 1'b0, 8'h00, 56'h0, p[3:0], i[3:0]});
         mode = 2'h0;
      end
   endtask

   task s_hold;
      begin
         base = app.n;
         p = pk;
         mode = 2'h2;
         send(1, 1, 1, 3'h1, -1, 0);
         nonposted_hold_request = 1'b1;
         send(1, 0, 1, 3'h3, -1, 0);
         fork
            send(1, 1, 1, 3'h2, -1, 0);
            begin
               repeat (20) @(posedge clk);
               chk(sent, 1'b0);
               chk(tl_np_stall_r, 1'b1);
               mode = 2'h0;
               wait_n(2);
               chk(app.cap[base], {3'b110, 8'h02, 56'h0, p[3:0], 4'h0});
               chk(app.cap[base + 1], {3'b110, 8'h08, 56'h0, p[3:0] + 4'h1, 4'h0});
               @(negedge clk);
               nonposted_hold_request = 1'b0;
            end
         join
         wait_n(3);
         chk(app.cap[base + 2], {3'b110, 8'h04, 56'h0, p[3:0] + 4'h2, 4'h0});
      end
   endtask

   // upstream marks last beats void, which a 64-bit port must never pass on
   always @(posedge clk) begin
      if (rcv_beat_valid === 1'b1) begin
         chk(rcv_upper_qword_void, 1'b0);
      end
   end

   // whole run needs just over a hundred cycles; the ceiling leaves ample margin
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         end_of_test;
      end
   end

   initial begin
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      s_bar;
      s_ecc;
      s_burst;
      s_hold;
      end_of_test;
   end
endmodule
